// ==== hdl/sirc_ctrl.v ====
// Purpose: idle/stop power modes and ring/crystal system clock control with APB registers
// Assumes: clock gates and clock mux sit outside; interrupt logic gives enable/pending levels
// Notes: crystal periods are counted from a monitored crystal level sampled on the core clock
//   the crystal must run slower than half the core clock or periods are missed
//   wake holds until both warm-up counts finish; a dead crystal keeps the core in wake
//   the switch module owns the clock mux select, the gate and the ring enable
//   a stop exit always restarts both warm-up counts from zero
//   only the synchronised pin levels feed the state machine
// How it works
// RULE1: stop exit with ring: ring until crystal settles
// RULE2: ring startup only when ring_start_select is 1
// RULE3: without ring, hold CPU 65536 crystal periods
// RULE4: readable ring_clock_active status bit
// RULE5: ring running forces divide 10b, writes ignored
// RULE6: watchdog always clocked from crystal
// RULE7: idle bit write freezes fetch after it
// RULE8: idle keeps peripheral clocks; interrupt ends idle
// RULE9: idle bit self-clears on idle exit
// RULE10: any processor reset ends idle
// RULE11: stop bit halts all clocks and crystal
// RULE12: enabled external interrupt ends stop
// RULE13: external reset pin always ends stop
// RULE14: undervoltage reset in stop only with bandgap_in_stop
// RULE15: 65536-cycle flash warm-up after stop
// RULE16: reset returns divide select to 10b
// RULE17: glitch-free ring/crystal clock switching
//
// Implementation choices: the register addresses and the APB interface to the registers.
`include "sirc_map.vh"
`default_nettype none

module sirc_ctrl #(
  parameter [16:0] FLASH_WARM_CYC = `SIRC_FLASH_WARM_CYC,
  parameter [16:0] XTAL_WARM_CYC = `SIRC_XTAL_WARM_CYC
) (
  input wire i_core_clk,
  input wire i_nrst,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [7:0] i_paddr,
  input wire [31:0] i_pwdata,
  output reg [31:0] o_prdata,
  output reg o_pready,
  output reg o_pslverr,
  input wire i_proc_rst,
  input wire i_irq_pending,
  input wire [5:0] i_ext_int_en,
  input wire [5:0] i_ext_int_pin,
  input wire i_ext_rst_pin,
  input wire i_vcc_low,
  input wire i_xtal_mon,
  output reg o_xtal_en,
  output wire o_ring_osc_en,
  output wire o_sysclk_ring_sel,
  output wire o_sysclk_gate_en,
  output reg o_cpu_clk_en,
  output reg o_periph_clk_en,
  output reg o_wdt_clk_ring,
  output reg [1:0] o_clk_div_sel,
  output reg o_uv_reset
);

  // one-hot power states, shown raw in the status register
  localparam ST_RUN = 4'b0001;
  localparam ST_IDLE = 4'b0010;
  localparam ST_STOP = 4'b0100;
  localparam ST_WAKE = 4'b1000;

  reg [3:0] st_reg;
  reg [3:0] st_next;

  // software-visible control bits, plus ring_mode_reg, the unreadable ring choice latched for a wake
  reg idle_reg;
  reg stop_reg;
  reg bandgap_stop_reg;
  reg ring_sel_reg;
  reg ring_mode_reg;

  // warm-up bookkeeping; counters and done flags cleared on every stop exit, xtal_prev_reg follows the crystal every cycle
  reg xtal_prev_reg;
  reg [16:0] flash_cnt_reg;
  reg [16:0] xtal_cnt_reg;
  reg flash_done_reg;
  reg xtal_done_reg;

  // pin levels after the synchroniser
  wire [5:0] ext_int_s;
  wire ext_rst_s;
  wire vcc_low_s;
  wire xtal_s;

  // decode and handshake helpers
  wire ring_active;
  wire want_ring;
  wire wr_acc;
  wire rd_setup;
  wire stop_wake;
  wire xtal_tick;
  wire any_rst;
  reg [31:0] rdata_next;
  reg addr_ok;

  // pins cross into the core domain before any logic looks at them
  // crystal monitor included: its level is asynchronous like any pin
  sirc_sync #(
    .W(9)
  ) u_sync (
    .i_core_clk(i_core_clk),
    .i_nrst(i_nrst),
    .i_async({i_ext_int_pin, i_ext_rst_pin, i_vcc_low, i_xtal_mon}),
    .o_sync({ext_int_s, ext_rst_s, vcc_low_s, xtal_s})
  );

  // ring wanted only while waking in ring mode and crystal not yet settled
  // dropping want_ring starts the switch back to the crystal
  assign want_ring = st_reg[3] & ring_mode_reg & ~xtal_done_reg; // [RULE1]

  // all glitch-free source changes happen inside the switch [RULE17]
  // the divide lock below keys on both want_ring and the mux select
  sirc_clk_switch u_switch (
    .i_core_clk(i_core_clk),
    .i_nrst(i_nrst),
    .i_want_ring(want_ring),
    .o_ring_osc_en(o_ring_osc_en),
    .o_sel_ring(o_sysclk_ring_sel),
    .o_gate_en(o_sysclk_gate_en)
  );

  assign ring_active = o_sysclk_ring_sel; // [RULE4]
  // write strobe fires once, on the access edge with ready high
  assign wr_acc = i_psel & i_penable & o_pready & i_pwrite;
  assign rd_setup = i_psel & ~i_penable;
  assign xtal_tick = xtal_s & ~xtal_prev_reg;
  assign any_rst = i_proc_rst | ext_rst_s; // [RULE10]
  // enabled external interrupt or reset pin ends stop
  assign stop_wake = (|(ext_int_s & i_ext_int_en)) | ext_rst_s; // [RULE12] [RULE13]

  // register read mux and address decode
  always @* begin
    rdata_next = 32'h00000000;
    addr_ok = 1'b1;
    case (i_paddr)
      // mode bits read back as the state machine sees them
      `SIRC_OFF_PWR_CTL: begin
        rdata_next[`SIRC_PWR_IDLE_BIT] = idle_reg;
        rdata_next[`SIRC_PWR_STOP_BIT] = stop_reg;
        rdata_next[`SIRC_PWR_BANDGAP_STOP_BIT] = bandgap_stop_reg;
      end
      `SIRC_OFF_EXT_FLAG: begin
        rdata_next[`SIRC_EXT_RING_SEL_BIT] = ring_sel_reg;
        rdata_next[`SIRC_EXT_RING_ACT_BIT] = ring_active; // [RULE4]
      end
      `SIRC_OFF_PWR_MGMT: begin
        rdata_next[`SIRC_DIV_HI_BIT] = o_clk_div_sel[1];
        rdata_next[`SIRC_DIV_LO_BIT] = o_clk_div_sel[0];
      end
      // debug view: raw state code and both warm-up flags
      `SIRC_OFF_STATUS: begin
        rdata_next[3:0] = st_reg;
        rdata_next[4] = flash_done_reg;
        rdata_next[5] = xtal_done_reg;
      end
      // holes in the map answer with an error and read zero
      default: begin
        addr_ok = 1'b0;
      end
    endcase
  end

  // zero-wait slave: answer registered in setup, presented for the access edge
  always @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_pready <= 1'b0;
      o_prdata <= 32'h00000000;
      o_pslverr <= 1'b0;
    end else begin
      // ready lasts exactly the access cycle, so a write lands once
      o_pready <= rd_setup;
      if (rd_setup) begin
        // data captured at setup and frozen through the access edge
        o_prdata <= i_pwrite ? 32'h00000000 : rdata_next;
        o_pslverr <= ~addr_ok;
      end else begin
        o_pslverr <= 1'b0;
      end
    end
  end

  // power mode sequencing
  always @* begin
    st_next = st_reg;
    case (st_reg)
      ST_RUN: begin
        // the write is taken on the access edge, so the mode starts at once
        if (wr_acc && i_paddr == `SIRC_OFF_PWR_CTL && i_pwdata[`SIRC_PWR_STOP_BIT]) begin
          st_next = ST_STOP; // stop wins if both bits written [RULE11]
        end else if (wr_acc && i_paddr == `SIRC_OFF_PWR_CTL && i_pwdata[`SIRC_PWR_IDLE_BIT]) begin
          st_next = ST_IDLE; // [RULE7]
        end
      end
      ST_IDLE: begin
        // peripherals keep running here, so any enabled source may wake
        if (i_irq_pending || any_rst) begin
          st_next = ST_RUN; // [RULE8] [RULE10]
        end
      end
      ST_STOP: begin
        // interrupts wake only when enabled; the pin reset bypasses the enables
        if (stop_wake || i_proc_rst) begin
          st_next = ST_WAKE;
        end
      end
      ST_WAKE: begin
        // leave only once flash and crystal are both settled and crystal drives again
        if (flash_done_reg && xtal_done_reg && !ring_active && !want_ring) begin
          st_next = ST_RUN; // [RULE15]
        end
      end
      default: begin
        st_next = ST_RUN;
      end
    endcase
  end

  // state, control bits and warm-up counters
  always @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_reg <= ST_RUN;
      idle_reg <= 1'b0;
      stop_reg <= 1'b0;
      bandgap_stop_reg <= 1'b0;
      ring_sel_reg <= 1'b0;
      ring_mode_reg <= 1'b0;
      xtal_prev_reg <= 1'b0;
      flash_cnt_reg <= 17'h00000;
      xtal_cnt_reg <= 17'h00000;
      flash_done_reg <= 1'b0;
      xtal_done_reg <= 1'b0;
      o_clk_div_sel <= `SIRC_DIV_DEFAULT; // [RULE16]
    end else begin
      st_reg <= st_next;
      xtal_prev_reg <= xtal_s;
      // bandgap choice only matters while stopped
      if (wr_acc && i_paddr == `SIRC_OFF_PWR_CTL) begin
        bandgap_stop_reg <= i_pwdata[`SIRC_PWR_BANDGAP_STOP_BIT];
      end
      if (wr_acc && i_paddr == `SIRC_OFF_EXT_FLAG) begin
        ring_sel_reg <= i_pwdata[`SIRC_EXT_RING_SEL_BIT]; // [RULE2]
      end
      // divide select: reset and ring both pin it to divide-by-1
      // a reset input wins over a same-cycle divide write
      if (any_rst || ring_active || want_ring) begin
        o_clk_div_sel <= `SIRC_DIV_DEFAULT; // [RULE5] [RULE16]
      end else if (wr_acc && i_paddr == `SIRC_OFF_PWR_MGMT) begin
        o_clk_div_sel <= i_pwdata[`SIRC_DIV_HI_BIT:`SIRC_DIV_LO_BIT];
      end
      // status bits track the next state, so reads see the new mode at once
      idle_reg <= st_next[1]; // self-clears on exit [RULE9]
      stop_reg <= st_next[2];
      // counters restart on each stop exit; ring choice frozen for this wake
      if (st_reg[2] && st_next[3]) begin
        ring_mode_reg <= ring_sel_reg; // [RULE2]
        flash_cnt_reg <= 17'h00000;
        xtal_cnt_reg <= 17'h00000;
        flash_done_reg <= 1'b0;
        xtal_done_reg <= 1'b0;
      end else if (st_reg[3]) begin
        // crystal counts synced rising edges, one per period
        if (!flash_done_reg) begin
          flash_cnt_reg <= flash_cnt_reg + 17'h00001;
          flash_done_reg <= (flash_cnt_reg == FLASH_WARM_CYC - 17'h00001); // [RULE15]
        end
        if (!xtal_done_reg && xtal_tick) begin
          xtal_cnt_reg <= xtal_cnt_reg + 17'h00001;
          xtal_done_reg <= (xtal_cnt_reg == XTAL_WARM_CYC - 17'h00001); // [RULE3]
        end
      end
    end
  end

  // clock enables and undervoltage reset
  always @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_xtal_en <= 1'b1;
      o_cpu_clk_en <= 1'b1;
      o_periph_clk_en <= 1'b1;
      o_wdt_clk_ring <= 1'b0;
      o_uv_reset <= 1'b0;
    end else begin
      // driven from st_next so enables move on the same edge as the state
      o_xtal_en <= ~st_next[2]; // crystal off in stop [RULE11]
      o_periph_clk_en <= ~st_next[2]; // [RULE8] [RULE11]
      o_wdt_clk_ring <= 1'b0; // watchdog never on the ring [RULE6]
      // cpu runs early only in ring mode, and never before flash warm-up
      o_cpu_clk_en <= st_next[0] | (st_reg[3] & st_next[3] & flash_done_reg & ring_mode_reg) |
                      (st_reg[3] & st_next[0]); // [RULE1] [RULE3] [RULE7]
      // request only while stopped; outside stop the supply monitor elsewhere owns it
      o_uv_reset <= st_reg[2] & bandgap_stop_reg & vcc_low_s; // [RULE14]
    end
  end

endmodule // sirc_ctrl

`default_nettype wire

// ==== hdl/sirc_map.vh ====
// Purpose: offsets, field positions, reset values and counts for the stop/idle/ring clock control
// Assumes: APB, 32-bit data, one aligned word per register
// Notes: definitions only
`ifndef SIRC_MAP_VH
`define SIRC_MAP_VH

// register byte offsets
`define SIRC_OFF_PWR_CTL 8'h00
`define SIRC_OFF_EXT_FLAG 8'h04
`define SIRC_OFF_PWR_MGMT 8'h08
`define SIRC_OFF_STATUS 8'h0C

// power_control_register fields
`define SIRC_PWR_IDLE_BIT 0
`define SIRC_PWR_STOP_BIT 1
`define SIRC_PWR_BANDGAP_STOP_BIT 2

// ext_flag_register fields
`define SIRC_EXT_RING_SEL_BIT 1
`define SIRC_EXT_RING_ACT_BIT 3

// power_mgmt_register clock divide select field
`define SIRC_DIV_HI_BIT 7
`define SIRC_DIV_LO_BIT 6
`define SIRC_DIV_DEFAULT 2'h2
`define SIRC_DIV_1024 2'h3

// warm-up counts
`define SIRC_FLASH_WARM_CYC 17'h10000
`define SIRC_XTAL_WARM_CYC 17'h10000
// clock gates stay off one cycle more than this count on each side of a source change
`define SIRC_SWITCH_GAP 2'h2

`endif

// ==== hdl/sirc_sync.v ====
// Purpose: two-flop synchroniser for a group of pin levels
// Assumes: inputs are quasi-static levels from outside the core clock domain
// Notes: only the second stage may be read by other logic
`default_nettype none

module sirc_sync #(
  parameter W = 1
) (
  input wire i_core_clk,
  input wire i_nrst,
  input wire [W-1:0] i_async,
  output reg [W-1:0] o_sync
);

  reg [W-1:0] meta_reg;

  // first stage feeds only the second stage
  always @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      meta_reg <= {W{1'b0}};
      o_sync <= {W{1'b0}};
    end else begin
      meta_reg <= i_async;
      o_sync <= meta_reg;
    end
  end

endmodule // sirc_sync

`default_nettype wire

// ==== hdl/sirc_clk_switch.v ====
// Purpose: break-before-make selection between ring and crystal system clock
// Assumes: downstream clock mux changes over only while both gates are off
// Notes: ring oscillator itself is enabled only while selected or during a switch to or from it
`include "sirc_map.vh"
`default_nettype none

module sirc_clk_switch (
  input wire i_core_clk,
  input wire i_nrst,
  input wire i_want_ring,
  output reg o_ring_osc_en,
  output reg o_sel_ring,
  output reg o_gate_en
);

  localparam ST_RUN = 3'b001;
  localparam ST_OFF = 3'b010;
  localparam ST_ON = 3'b100;

  reg [2:0] st_reg;
  reg [1:0] gap_reg;

  // gate off, wait, change select, wait, gate on: no runt pulse reaches the core [RULE17]
  always @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_reg <= ST_RUN;
      gap_reg <= 2'h0;
      o_ring_osc_en <= 1'b0;
      o_sel_ring <= 1'b0;
      o_gate_en <= 1'b1;
    end else begin
      case (st_reg)
        ST_RUN: begin
          if (i_want_ring != o_sel_ring) begin
            o_gate_en <= 1'b0; // [RULE17]
            gap_reg <= `SIRC_SWITCH_GAP;
            if (i_want_ring) begin
              o_ring_osc_en <= 1'b1;
            end
            st_reg <= ST_OFF;
          end
        end
        ST_OFF: begin
          if (gap_reg != 2'h0) begin
            gap_reg <= gap_reg - 2'h1;
          end else begin
            o_sel_ring <= i_want_ring; // select moves only with both gates closed [RULE17]
            gap_reg <= `SIRC_SWITCH_GAP;
            st_reg <= ST_ON;
          end
        end
        ST_ON: begin
          if (gap_reg != 2'h0) begin
            gap_reg <= gap_reg - 2'h1;
          end else begin
            o_gate_en <= 1'b1;
            if (!o_sel_ring) begin
              o_ring_osc_en <= 1'b0; // ring off once crystal drives [RULE1]
            end
            st_reg <= ST_RUN;
          end
        end
        default: begin
          st_reg <= ST_RUN;
        end
      endcase
    end
  end

endmodule // sirc_clk_switch

`default_nettype wire

// ==== hdl/sirc_none.v ====
// Purpose: empty unit kept so the source list stays stable
// Assumes: nothing
// Notes: holds no logic
`default_nettype none
`default_nettype wire

// ==== dv/sirc_ctrl_sva.sv ====
// Purpose: port-level property checks for the stop/idle/ring clock control
// Assumes: one core clock, asynchronous active-low reset
// Notes: bound to every sirc_ctrl instance
`default_nettype none
module sirc_ctrl_sva #(
  parameter [16:0] FLASH_WARM_CYC = 17'h10000,
  parameter [16:0] XTAL_WARM_CYC = 17'h10000
) (
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_ext_rst_pin,
  input wire logic o_pready,
  input wire logic o_xtal_en,
  input wire logic o_ring_osc_en,
  input wire logic o_sysclk_ring_sel,
  input wire logic o_sysclk_gate_en,
  input wire logic o_cpu_clk_en,
  input wire logic o_periph_clk_en,
  input wire logic o_wdt_clk_ring,
  input wire logic [1:0] o_clk_div_sel,
  input wire logic o_uv_reset
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);
  // clock source relations
  AST_WDT_XTAL: assert property (o_wdt_clk_ring == 1'b0) else $error("watchdog left the crystal");
  AST_RING_DIV: assert property (o_sysclk_ring_sel |-> o_clk_div_sel == 2'h2) else $error("divide not 1 on ring");
  AST_RING_OSC: assert property (o_sysclk_ring_sel |-> o_ring_osc_en) else $error("ring selected but off");
  // mux may only change while the gate has been shut for two edges
  AST_SWITCH_GAP: assert property ($changed(o_sysclk_ring_sel) |-> !o_sysclk_gate_en && !$past(o_sysclk_gate_en))
    else $error("source changed with gate open");
  // power mode relations
  AST_STOP_CLKS: assert property (!o_xtal_en |-> !o_cpu_clk_en && !o_periph_clk_en) else $error("clock on in stop");
  AST_CPU_PERIPH: assert property (o_cpu_clk_en |-> o_periph_clk_en) else $error("peripherals off while running");
  AST_WARM_HOLD: assert property ($rose(o_xtal_en) |-> !o_cpu_clk_en [*8]) else $error("cpu ran before warm-up");
  AST_EXT_RST_WAKE: assert property (!o_xtal_en && i_ext_rst_pin |-> ##[1:6] o_xtal_en)
    else $error("reset pin did not end stop");
  AST_UV_STOP: assert property (o_uv_reset |-> !o_cpu_clk_en) else $error("undervoltage reset outside stop");
  AST_APB_ACK: assert property (i_psel && !i_penable |=> o_pready) else $error("no ready after setup");
  // main scenarios reached
  COV_RING: cover property ($rose(o_sysclk_ring_sel));
  COV_STOP: cover property ($fell(o_xtal_en));
  COV_UV: cover property (o_uv_reset);
  COV_IDLE: cover property ($fell(o_cpu_clk_en) && o_xtal_en);
endmodule // sirc_ctrl_sva
bind sirc_ctrl sirc_ctrl_sva #(.FLASH_WARM_CYC(FLASH_WARM_CYC), .XTAL_WARM_CYC(XTAL_WARM_CYC)) u_sva (.*);
`default_nettype wire

// ==== dv/sirc_xtal_model.sv ====
// Purpose: crystal oscillator stand-in on the far side of the clock control
// Assumes: oscillates only while enabled
// Notes: parks low when disabled, as a stopped crystal does
`default_nettype none
module sirc_xtal_model #(
  parameter int HALF_NS = 12
) (
  input wire logic i_en,
  output logic o_xtal
);
  timeunit 1ns;
  timeprecision 1ps;
  // half period never lands on a rising core clock edge
  initial begin
    o_xtal = 1'b0;
    forever begin
      #(HALF_NS);
      o_xtal = i_en ? ~o_xtal : 1'b0;
    end
  end
endmodule // sirc_xtal_model
`default_nettype wire

// ==== dv/sirc_ctrl_tb.sv ====
// Purpose: directed bench for the stop/idle/ring clock control
// Assumes: short warm-up counts, crystal model period 24 ns
// Notes: one task per scenario; inputs move just after rising edges
`include "sirc_map.vh"
`default_nettype none
module sirc_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam [16:0] FW = 17'h10;
  localparam [16:0] XW = 17'h10;
  localparam int XP = 24;
  logic clk = 1'b0, nrst = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, proc_rst = 1'b0;
  logic irq = 1'b0, ext_rst = 1'b0, vlow = 1'b0, pready, perr, err_val, xtal, ring_seen;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd_val;
  logic [5:0] int_en = 6'h00, int_pin = 6'h00;
  logic xen, rosc, rsel, gate, cpu, per, wdt, uv;
  logic [1:0] div;
  int errors = 0, total_checks = 0, n;
  always #2.5 clk = ~clk;
  sirc_xtal_model #(.HALF_NS(XP / 2)) u_xtal (.i_en(xen), .o_xtal(xtal));
  sirc_ctrl #(.FLASH_WARM_CYC(FW), .XTAL_WARM_CYC(XW)) dut (.i_core_clk(clk), .i_nrst(nrst),
    .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(perr), .i_proc_rst(proc_rst), .i_irq_pending(irq),
    .i_ext_int_en(int_en), .i_ext_int_pin(int_pin), .i_ext_rst_pin(ext_rst), .i_vcc_low(vlow),
    .i_xtal_mon(xtal), .o_xtal_en(xen), .o_ring_osc_en(rosc), .o_sysclk_ring_sel(rsel),
    .o_sysclk_gate_en(gate), .o_cpu_clk_en(cpu), .o_periph_clk_en(per), .o_wdt_clk_ring(wdt),
    .o_clk_div_sel(div), .o_uv_reset(uv));
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // a used-up wait bound ends the run
  task automatic tmo(input int cnt);
    if (cnt >= 400) begin
      chk("wait_bound", 1'b0, 1'b1);
      final_report();
    end
  endtask
  // apb transfer; holds the request until ready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 400);
    tmo(k);
    rd_val = prdata;
    err_val = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic t_reset();
    chk("div_sel", div, 2'h2);
    chk("wdt_src", wdt, 1'b0);
    apb(1'b0, 8'h40, 32'h0);
    chk("bad_addr_err", err_val, 1'b1);
    apb(1'b0, `SIRC_OFF_PWR_MGMT, 32'h0);
    chk("div_reg", rd_val, 32'h80);
    $display("reset test done");
  endtask
  task automatic t_idle();
    apb(1'b1, `SIRC_OFF_PWR_CTL, 32'h1);
    repeat (2) @(posedge clk);
    chk("idle_cpu", cpu, 1'b0);
    chk("idle_periph", per, 1'b1);
    irq <= 1'b1;
    repeat (3) @(posedge clk);
    irq <= 1'b0;
    chk("irq_wakes", cpu, 1'b1);
    apb(1'b0, `SIRC_OFF_PWR_CTL, 32'h0);
    chk("idle_bit", rd_val[0], 1'b0);
    apb(1'b1, `SIRC_OFF_PWR_CTL, 32'h1);
    proc_rst <= 1'b1;
    repeat (3) @(posedge clk);
    proc_rst <= 1'b0;
    apb(1'b0, `SIRC_OFF_PWR_CTL, 32'h0);
    chk("rst_idle_bit", rd_val[0], 1'b0);
    chk("rst_idle_cpu", cpu, 1'b1);
    $display("idle test done");
  endtask
  // stop without ring: masked pin, no bandgap, reset pin wakes
  task automatic t_stop_xtal();
    apb(1'b1, `SIRC_OFF_EXT_FLAG, 32'h0);
    apb(1'b1, `SIRC_OFF_PWR_CTL, 32'h2);
    int_pin <= 6'h01;
    vlow <= 1'b1;
    repeat (10) @(posedge clk);
    chk("stop_xtal", xen, 1'b0);
    chk("stop_periph", per, 1'b0);
    chk("uv_no_bgs", uv, 1'b0);
    vlow <= 1'b0;
    int_pin <= 6'h00;
    ext_rst <= 1'b1;
    for (n = 0; n < 400 && xen !== 1'b1; n++) @(posedge clk);
    tmo(n);
    ext_rst <= 1'b0;
    ring_seen = 1'b0;
    for (n = 0; n < 400 && cpu !== 1'b1; n++) begin
      @(posedge clk);
      ring_seen |= rosc;
    end
    tmo(n);
    chk("xtal_hold", n >= XW * XP / 5, 1'b1);
    chk("no_ring", ring_seen, 1'b0);
    chk("gate_xtal", gate, 1'b1);
    $display("stop crystal test done");
  endtask
  // stop with ring and bandgap, enabled pin 5 wakes
  task automatic t_stop_ring();
    apb(1'b1, `SIRC_OFF_EXT_FLAG, 32'h2);
    apb(1'b1, `SIRC_OFF_PWR_CTL, 32'h6);
    vlow <= 1'b1;
    for (n = 0; n < 20 && uv !== 1'b1; n++) @(posedge clk);
    chk("uv_bgs", uv, 1'b1);
    vlow <= 1'b0;
    int_en <= 6'h20;
    int_pin <= 6'h20;
    for (n = 0; n < 400 && rsel !== 1'b1; n++) @(posedge clk);
    tmo(n);
    chk("gate_shut", gate, 1'b0);
    int_pin <= 6'h00;
    for (n = 0; n < 400 && cpu !== 1'b1; n++) @(posedge clk);
    tmo(n);
    chk("ring_runs_cpu", rsel, 1'b1);
    chk("gate_ring", gate, 1'b1);
    apb(1'b1, `SIRC_OFF_PWR_MGMT, 32'hC0);
    apb(1'b0, `SIRC_OFF_EXT_FLAG, 32'h0);
    chk("ring_active", rd_val[3], 1'b1);
    apb(1'b0, `SIRC_OFF_PWR_MGMT, 32'h0);
    chk("div_locked", rd_val, 32'h80);
    for (n = 0; n < 400 && rsel !== 1'b0; n++) @(posedge clk);
    tmo(n);
    repeat (4) @(posedge clk);
    chk("ring_off", rosc, 1'b0);
    apb(1'b0, `SIRC_OFF_EXT_FLAG, 32'h0);
    chk("ring_idle", rd_val[3], 1'b0);
    apb(1'b1, `SIRC_OFF_PWR_MGMT, 32'hC0);
    apb(1'b0, `SIRC_OFF_PWR_MGMT, 32'h0);
    chk("div_free", rd_val, 32'hC0);
    chk("div_out", div, 2'h3);
    proc_rst <= 1'b1;
    repeat (2) @(posedge clk);
    proc_rst <= 1'b0;
    repeat (2) @(posedge clk);
    chk("div_after_rst", div, 2'h2);
    $display("stop ring test done");
  endtask
  initial begin
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_idle();
    t_stop_xtal();
    t_stop_ring();
    final_report();
  end
endmodule // sirc_ctrl_tb
`default_nettype wire
